/* File: gated_sixteen_bit_timer.sv */
// Purpose: 16-bit gated timer with prescaler, capture/compare time base and APB registers.
// Assumes: All inputs synchronous to ref_clk_i; the external clock is sampled.
// Notes:   The asynchronous path is modelled on samples of the external clock pin.
// Contract
// RULE1 - 16-bit counter, byte writes update immediately
// RULE2 - Clock source select picks instruction or external
// RULE3 - External rising edges increment, sync or async
// RULE4 - Falling edge needed before first counted rise
// RULE5 - Prescaler divides by one, two, four, eight
// RULE6 - Prescaler hidden, cleared on counter write
// RULE7 - Oscillator enable runs low-power crystal clock
// RULE8 - Oscillator allowed only with suitable system clock
// RULE9 - Oscillator pins read direction 1, data 0
// RULE10 - Sync disable counts unsynchronised, also in sleep
// RULE11 - Sync mode switch may gain or lose one
// RULE12 - Byte reads are valid in async mode
// RULE13 - Software stops timer before async counter writes
// RULE14 - Gate from pin or comparator when enabled
// RULE15 - Gate invert applies to either source
// RULE16 - Wrap max to zero, set overflow flag
// RULE17 - Interrupt needs on, enable, peripheral, global bits
// RULE18 - Async overflow wakes from sleep, vectors if global
// RULE19 - Counter is capture and compare time base
// RULE20 - Special trigger clears counter, no overflow flag
// RULE21 - Counter write beats special trigger
// RULE22 - Software uses sync counting with special trigger
// RULE23 - Prescale codes 00..11 give 1,2,4,8
// RULE24 - Gated count while gate matches invert polarity
// RULE25 - Counts only when timer on bit set
`timescale 1ns/10ps
`include "gated_timer_regs.svh"
module gated_sixteen_bit_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic        ref_clk_i,        // System clock, 40 MHz.
    input  wire logic        reset_i,          // Synchronous reset, active high.
    input  wire logic        psel,             // APB select.
    input  wire logic        penable,          // APB access phase.
    input  wire logic        pwrite,           // APB write.
    input  wire logic [11:0] paddr,            // APB byte address.
    input  wire logic [31:0] pwdata,           // APB write data.
    output logic      [31:0] prdata,           // APB read data.
    output logic             pready,           // APB ready.
    output logic             pslverr,          // APB error on unmapped address.
    input  wire logic        instr_clk_en_i,   // Instruction clock tick, Fosc/4.
    input  wire logic        ext_clk_i,        // External count clock pin.
    input  wire logic        lp_osc_clk_i,     // Low-power crystal oscillator output.
    input  wire logic        osc_mode_ok_i,    // System clock allows the shared oscillator.
    input  wire logic        sleep_i,          // Device is asleep.
    input  wire logic        gate_pin_i,       // Gate input pin.
    input  wire logic        comp2_out_i,      // Second comparator output.
    input  wire logic        capture_evt_i,    // Capture event from the capture unit.
    input  wire logic        special_trig_i,   // Special event trigger.
    input  wire logic        osc_a_dir_i,      // Port direction latch, pin a.
    input  wire logic        osc_b_dir_i,      // Port direction latch, pin b.
    input  wire logic        osc_a_data_i,     // Port data, pin a.
    input  wire logic        osc_b_data_i,     // Port data, pin b.
    output logic             osc_run_o,        // Low-power oscillator running.
    output logic [CNT_W-1:0] count_o,          // Counter value, time base.
    output logic             compare_match_o,  // Compare pair equals counter.
    output logic             irq_o,            // Rollover interrupt request.
    output logic             wake_o,           // Wake from sleep request.
    output logic             vector_o          // Vector to service routine on wake.
);
    import gated_timer_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [2:0]       pre;
        logic [8:0]       ctl;
        logic [2:0]       ien;
        logic             ovf;
        logic [CNT_W-1:0] cap;
        logic [CNT_W-1:0] cmp;
        logic             src_d;
        ext_arm_t         arm;
        logic [31:0]      rdata;
        logic             wake;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    function automatic logic [2:0] pre_max(input logic [1:0] sel);
        case (sel) // see RULE23
            2'h0:    pre_max = 3'h0;
            2'h1:    pre_max = 3'h1;
            2'h2:    pre_max = 3'h3;
            default: pre_max = 3'h7;
        endcase
    endfunction

    logic       acc;
    logic       rd_setup;
    logic       wr;
    logic       mapped;
    logic       on;
    logic       ext_sel;
    logic       osc_en;
    logic       src;
    logic       gate_raw;
    logic       gate_ok;
    logic       tick;
    logic       pre_done;
    logic       inc;
    logic       cnt_wr;
    logic [7:0] wb;

    assign acc     = psel && penable;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr      = acc && pwrite;
    assign wb      = pwdata[7:0];
    assign on      = st_ff.ctl[`CTL_TIMER_ON];
    assign ext_sel = st_ff.ctl[`CTL_CLK_SEL];                       // see RULE2
    assign osc_en  = st_ff.ctl[`CTL_OSC_EN] && osc_mode_ok_i;       // see RULE8
    assign src     = osc_en ? lp_osc_clk_i : ext_clk_i;             // see RULE7
    assign gate_raw = st_ff.ctl[`CTL_GATE_SRC] ? comp2_out_i : gate_pin_i; // see RULE14
    assign gate_ok = !st_ff.ctl[`CTL_GATE_EN] ||
                     (gate_raw == st_ff.ctl[`CTL_GATE_INV]);        // see RULE15, RULE24
    assign cnt_wr  = wr && (paddr == `OFS_COUNT_LOW || paddr == `OFS_COUNT_HIGH);
    assign mapped  = paddr inside {`OFS_COUNT_LOW, `OFS_COUNT_HIGH, `OFS_CONTROL,
                                   `OFS_STATUS, `OFS_IRQ_ENABLE, `OFS_CAPTURE_LOW,
                                   `OFS_CAPTURE_HIGH, `OFS_COMPARE_LOW,
                                   `OFS_COMPARE_HIGH, `OFS_OSC_PORT};

    // Sampled pin keeps the same edge model in both sync modes; sleep stops
    // the instruction clock so only the unsynchronised external path survives.
    always_comb begin
        if (ext_sel) begin
            tick = src && !st_ff.src_d && st_ff.arm == EXT_ARMED &&
                   (!sleep_i || st_ff.ctl[`CTL_SYNC_DIS]);  // see RULE3, RULE10, RULE11
        end else begin
            tick = instr_clk_en_i && !sleep_i;
        end
    end

    assign pre_done = st_ff.pre == pre_max(st_ff.ctl[`CTL_PRESCALE_LO +: 2]); // see RULE5
    assign inc      = on && gate_ok && tick && pre_done;            // see RULE25

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.src_d = src;
        nxt_st.wake  = 1'b0;
        if (!src && st_ff.src_d) begin
            nxt_st.arm = EXT_ARMED;                                 // see RULE4
        end
        if (!on) begin
            nxt_st.arm = EXT_WAIT_FALL;                             // see RULE4
        end
        if (on && gate_ok && tick) begin
            nxt_st.pre = pre_done ? `PRESCALE_ZERO : st_ff.pre + 3'h1;
        end
        if (inc) begin
            nxt_st.count = st_ff.count + 16'h0001;
            if (st_ff.count == `COUNT_MAX) begin
                nxt_st.ovf  = 1'b1;                                 // see RULE16
                nxt_st.wake = sleep_i && st_ff.ien[`IEN_OVF] &&
                              st_ff.ien[`IEN_PERIPH];               // see RULE18
            end
        end
        if (special_trig_i) begin
            nxt_st.count = `COUNT_ZERO;                             // see RULE20
        end
        if (capture_evt_i) begin
            nxt_st.cap = st_ff.count;                               // see RULE19
        end
        // Read data is captured in the setup phase so it stands at the access edge.
        if (rd_setup) begin
            case (paddr)
                `OFS_COUNT_LOW:    nxt_st.rdata = {24'h0, st_ff.count[7:0]};  // see RULE12
                `OFS_COUNT_HIGH:   nxt_st.rdata = {24'h0, st_ff.count[15:8]};
                `OFS_CONTROL:      nxt_st.rdata = {23'h0, st_ff.ctl};
                `OFS_STATUS:       nxt_st.rdata = {31'h0, st_ff.ovf};
                `OFS_IRQ_ENABLE:   nxt_st.rdata = {29'h0, st_ff.ien};
                `OFS_CAPTURE_LOW:  nxt_st.rdata = {24'h0, st_ff.cap[7:0]};
                `OFS_CAPTURE_HIGH: nxt_st.rdata = {24'h0, st_ff.cap[15:8]};
                `OFS_COMPARE_LOW:  nxt_st.rdata = {24'h0, st_ff.cmp[7:0]};
                `OFS_COMPARE_HIGH: nxt_st.rdata = {24'h0, st_ff.cmp[15:8]};
                `OFS_OSC_PORT: begin
                    nxt_st.rdata = osc_en ? `OSC_VIEW_FORCED :        // see RULE9
                        {28'h0, osc_b_dir_i, osc_a_dir_i, osc_b_data_i, osc_a_data_i};
                end
                default:           nxt_st.rdata = 32'h0;
            endcase
        end
        if (wr) begin
            case (paddr)
                `OFS_COUNT_LOW:    nxt_st.count[7:0]  = wb;         // see RULE1, RULE21
                `OFS_COUNT_HIGH:   nxt_st.count[15:8] = wb;         // see RULE1, RULE21
                `OFS_CONTROL:      nxt_st.ctl = pwdata[8:0];
                `OFS_STATUS:       nxt_st.ovf = pwdata[0] && nxt_st.ovf;
                `OFS_IRQ_ENABLE:   nxt_st.ien = pwdata[2:0];
                `OFS_COMPARE_LOW:  nxt_st.cmp[7:0]  = wb;
                `OFS_COMPARE_HIGH: nxt_st.cmp[15:8] = wb;
                default:           ;
            endcase
        end
        // A status write of zero clears the flag unless a rollover sets it now.
        if (wr && paddr == `OFS_STATUS && inc && st_ff.count == `COUNT_MAX) begin
            nxt_st.ovf = 1'b1;
        end
        if (cnt_wr) begin
            nxt_st.pre = `PRESCALE_ZERO;                            // see RULE6
            nxt_st.arm = EXT_WAIT_FALL;                             // see RULE4
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_ff <= '{count: `COUNT_ZERO, pre: `PRESCALE_ZERO, ctl: `CTL_RESET,
                       ien: 3'h0, ovf: 1'b0, cap: `COUNT_ZERO, cmp: `COUNT_ZERO,
                       src_d: 1'b0, arm: EXT_WAIT_FALL, rdata: 32'h0, wake: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata          = st_ff.rdata;
    assign pready          = 1'b1;
    assign pslverr         = acc && !mapped;
    assign count_o         = st_ff.count;
    assign compare_match_o = st_ff.cmp == st_ff.count;               // see RULE19
    assign osc_run_o       = osc_en;
    assign irq_o           = st_ff.ovf && on && (&st_ff.ien);         // see RULE17
    assign wake_o          = st_ff.wake;
    assign vector_o        = st_ff.wake && st_ff.ien[`IEN_GLOBAL];   // see RULE18

    property p_wrap;
        @(posedge ref_clk_i) disable iff (reset_i)
        (inc && st_ff.count == `COUNT_MAX && !special_trig_i && !cnt_wr)
            |=> (st_ff.count == `COUNT_ZERO && st_ff.ovf);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Rollover failed."); // see RULE16

    property p_trig_clear;
        @(posedge ref_clk_i) disable iff (reset_i)
        (special_trig_i && !cnt_wr && !st_ff.ovf && !(inc && st_ff.count == `COUNT_MAX))
            |=> (st_ff.count == `COUNT_ZERO && !st_ff.ovf);
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("Trigger clear failed."); // see RULE20

    property p_write_wins;
        @(posedge ref_clk_i) disable iff (reset_i)
        (special_trig_i && wr && paddr == `OFS_COUNT_LOW)
            |=> st_ff.count[7:0] == $past(pwdata[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("Write lost to trigger."); // see RULE21

    property p_off_hold;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!on && !wr && !special_trig_i) |=> st_ff.count == $past(st_ff.count);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("Counted while off."); // see RULE25

    property p_pre_clear;
        @(posedge ref_clk_i) disable iff (reset_i)
        cnt_wr |=> (st_ff.pre == `PRESCALE_ZERO && st_ff.arm == EXT_WAIT_FALL);
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("Prescaler not cleared."); // see RULE6

    property p_gate_block;
        @(posedge ref_clk_i) disable iff (reset_i)
        (st_ff.ctl[`CTL_GATE_EN] && gate_raw != st_ff.ctl[`CTL_GATE_INV]) |-> !inc;
    endproperty
    a_gate_block: assert property (p_gate_block) else $error("Gate ignored."); // see RULE24

    property p_irq;
        @(posedge ref_clk_i) disable iff (reset_i)
        irq_o |-> (st_ff.ovf && on && st_ff.ien[`IEN_GLOBAL] && st_ff.ien[`IEN_PERIPH]);
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt without enables."); // see RULE17

    property p_osc_pins;
        @(posedge ref_clk_i) disable iff (reset_i)
        (rd_setup && paddr == `OFS_OSC_PORT && osc_en)
            |=> prdata == `OSC_VIEW_FORCED;
    endproperty
    a_osc_pins: assert property (p_osc_pins) else $error("Oscillator pins wrong."); // see RULE9

    sequence s_armed_rise;
        (ext_sel && on && st_ff.arm == EXT_WAIT_FALL && src && !st_ff.src_d);
    endsequence
    property p_need_fall;
        @(posedge ref_clk_i) disable iff (reset_i)
        s_armed_rise |-> !inc;
    endproperty
    a_need_fall: assert property (p_need_fall) else $error("Counted before fall."); // see RULE4

    property p_int_step;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!ext_sel && on && gate_ok && instr_clk_en_i && !sleep_i && pre_done &&
         !cnt_wr && !special_trig_i)
            |=> st_ff.count == $past(st_ff.count) + 16'h0001;
    endproperty
    a_int_step: assert property (p_int_step) else $error("Tick lost."); // see RULE2

    property p_ext_edge_only;
        @(posedge ref_clk_i) disable iff (reset_i)
        (ext_sel && !(src && !st_ff.src_d)) |-> !inc;
    endproperty
    a_ext_edge_only: assert property (p_ext_edge_only) else $error("Off edge."); // see RULE3

    property p_sleep_stop;
        @(posedge ref_clk_i) disable iff (reset_i)
        (sleep_i && !(ext_sel && st_ff.ctl[`CTL_SYNC_DIS])) |-> !inc;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("Sleep count."); // see RULE10

    property p_pre_wrap;
        @(posedge ref_clk_i) disable iff (reset_i)
        (on && gate_ok && tick && pre_done) |=> st_ff.pre == `PRESCALE_ZERO;
    endproperty
    a_pre_wrap: assert property (p_pre_wrap) else $error("Prescaler stuck."); // see RULE5

    property p_osc_gate;
        @(posedge ref_clk_i) disable iff (reset_i)
        !osc_mode_ok_i |-> !osc_run_o;
    endproperty
    a_osc_gate: assert property (p_osc_gate) else $error("Oscillator not allowed."); // see RULE8

    property p_osc_on;
        @(posedge ref_clk_i) disable iff (reset_i)
        (st_ff.ctl[`CTL_OSC_EN] && osc_mode_ok_i) |-> osc_run_o;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("Oscillator off."); // see RULE7

    property p_capture;
        @(posedge ref_clk_i) disable iff (reset_i)
        capture_evt_i |=> st_ff.cap == $past(st_ff.count);
    endproperty
    a_capture: assert property (p_capture) else $error("Capture lost."); // see RULE19

    property p_wake_flag;
        @(posedge ref_clk_i) disable iff (reset_i)
        wake_o |-> st_ff.ovf;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("Wake without flag."); // see RULE18

    property p_wake_sleep;
        @(posedge ref_clk_i) disable iff (reset_i)
        !sleep_i |=> !wake_o;
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("Wake while awake."); // see RULE18

    property p_ovf_keep;
        @(posedge ref_clk_i) disable iff (reset_i)
        (st_ff.ovf && !(wr && paddr == `OFS_STATUS && !pwdata[0]))
            |=> st_ff.ovf;
    endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("Flag dropped."); // see RULE17

    property p_ovf_clear;
        @(posedge ref_clk_i) disable iff (reset_i)
        (wr && paddr == `OFS_STATUS && !pwdata[0] && !(inc && st_ff.count == `COUNT_MAX))
            |=> !st_ff.ovf;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("Flag not cleared."); // see RULE17

    property p_off_disarm;
        @(posedge ref_clk_i) disable iff (reset_i)
        !on |=> st_ff.arm == EXT_WAIT_FALL;
    endproperty
    a_off_disarm: assert property (p_off_disarm) else $error("Armed while off."); // see RULE4

    property p_high_write;
        @(posedge ref_clk_i) disable iff (reset_i)
        (wr && paddr == `OFS_COUNT_HIGH)
            |=> st_ff.count[15:8] == $past(pwdata[7:0]);
    endproperty
    a_high_write: assert property (p_high_write) else $error("High byte lost."); // see RULE1

    property p_gate_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        (on && !st_ff.ctl[`CTL_GATE_EN] && tick && pre_done) |-> inc;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("Gate not ignored."); // see RULE14
endmodule

/* File: gated_timer_regs.svh */
// Purpose: Register offsets, field positions and reset values of the gated timer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
`ifndef GATED_TIMER_REGS_SVH
`define GATED_TIMER_REGS_SVH
`define OFS_COUNT_LOW     12'h000
`define OFS_COUNT_HIGH    12'h004
`define OFS_CONTROL       12'h008
`define OFS_STATUS        12'h00c
`define OFS_IRQ_ENABLE    12'h010
`define OFS_CAPTURE_LOW   12'h014
`define OFS_CAPTURE_HIGH  12'h018
`define OFS_COMPARE_LOW   12'h01c
`define OFS_COMPARE_HIGH  12'h020
`define OFS_OSC_PORT      12'h024
`define CTL_TIMER_ON      0
`define CTL_CLK_SEL       1
`define CTL_SYNC_DIS      2
`define CTL_OSC_EN        3
`define CTL_PRESCALE_LO   4
`define CTL_GATE_EN       6
`define CTL_GATE_INV      7
`define CTL_GATE_SRC      8
`define IEN_OVF           0
`define IEN_PERIPH        1
`define IEN_GLOBAL        2
`define CTL_RESET         9'h000
`define COUNT_MAX         16'hffff
`define COUNT_ZERO        16'h0000
`define PRESCALE_ZERO     3'h0
`define OSC_VIEW_FORCED   32'h0000_000c
`endif

/* File: gated_timer_pkg.sv */
// Purpose: Types shared by the gated timer.
// Assumes: Nothing beyond the register header.
// Notes:   Holds the external-edge arming state.
package gated_timer_pkg;
    typedef enum logic [0:0] {
        EXT_WAIT_FALL = 1'b0,
        EXT_ARMED     = 1'b1
    } ext_arm_t;
endpackage

/* File: ext_clock_model.sv */
// Purpose: External count clock source facing the timer's clock pin.
// Assumes: Levels change on system clock edges; each level lasts half_i plus one cycles.
// Notes:   The pin stands low between bursts, so every burst opens with a rise.
`timescale 1ns/10ps
module ext_clock_model (
    input  wire logic       ref_clk_i,  // System clock.
    input  wire logic       start_i,    // Begin a burst.
    input  wire logic [3:0] pulses_i,   // Whole pulses in the burst.
    input  wire logic [3:0] half_i,     // Extra cycles per level.
    output logic            ext_clk_o,  // Count clock pin.
    output logic            busy_o      // Burst in progress.
);
    logic [4:0] edges_ff;
    logic [3:0] wait_ff;
    initial begin
        ext_clk_o = 1'b0;
        busy_o    = 1'b0;
        edges_ff  = 5'h00;
        wait_ff   = 4'h0;
    end
    always @(posedge ref_clk_i) begin
        if (start_i && !busy_o) begin
            busy_o   <= 1'b1;
            edges_ff <= {pulses_i, 1'b0};
            wait_ff  <= half_i;
        end else if (busy_o && wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else if (busy_o && edges_ff != 5'h00) begin
            ext_clk_o <= ~ext_clk_o;
            edges_ff  <= edges_ff - 5'h01;
            wait_ff   <= half_i;
        end else begin
            busy_o <= 1'b0;
        end
    end
endmodule

/* File: gated_sixteen_bit_timer_bench.sv */
// Purpose: Self-checking bench for the gated sixteen-bit timer.
// Assumes: prdata is valid at the access edge.
// Notes:   Read expectations queue up for a monitor that compares them.
`timescale 1ns/10ps
`include "gated_timer_regs.svh"
module gated_sixteen_bit_timer_bench;
    logic        ref_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0;
    logic        tick      = 1'b0;
    logic        gate_pin  = 1'b0;
    logic        comp2     = 1'b0;
    logic        cap       = 1'b0;
    logic        trig      = 1'b0;
    logic        sleep     = 1'b0;
    logic        mode_ok   = 1'b0;
    logic [3:0]  port      = 4'h0;
    logic        start     = 1'b0;
    logic [3:0]  pulses    = 4'h0;
    logic [3:0]  half      = 4'h0;
    logic        trig_acc  = 1'b0;
    logic        perr;
    logic [31:0] prdata;
    logic        pready, pslverr, ext_clk, ext_busy, osc_run, match, irq, wake, vec;
    logic [15:0] count;
    logic [31:0] exp_q[$];
    int          err_count = 0;
    int          compares  = 0;
    int          wake_n    = 0;
    int          vec_n     = 0;
    int          seed      = 32'ha7a3f3c9;
    int          n;

    always #12.5 ref_clk_i = ~ref_clk_i;

    gated_sixteen_bit_timer u_gated_sixteen_bit_timer (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_clk_en_i(tick), .ext_clk_i(ext_clk),
        .lp_osc_clk_i(1'b0), .osc_mode_ok_i(mode_ok), .sleep_i(sleep),
        .gate_pin_i(gate_pin), .comp2_out_i(comp2), .capture_evt_i(cap),
        .special_trig_i(trig), .osc_a_dir_i(port[2]), .osc_b_dir_i(port[3]),
        .osc_a_data_i(port[0]), .osc_b_data_i(port[1]), .osc_run_o(osc_run),
        .count_o(count), .compare_match_o(match), .irq_o(irq), .wake_o(wake),
        .vector_o(vec)
    );
    ext_clock_model u_ext_clock_model (
        .ref_clk_i(ref_clk_i), .start_i(start), .pulses_i(pulses), .half_i(half),
        .ext_clk_o(ext_clk), .busy_o(ext_busy)
    );

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(posedge ref_clk_i) begin
        if (psel && penable && !pwrite && pready === 1'b1) chk("prdata", exp_q.pop_front(), prdata);
        if (wake === 1'b1) wake_n++;
        if (vec === 1'b1) vec_n++;
    end
    // The special trigger, when asked for, rides on the access cycle of the transfer.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        trig <= trig_acc;
        @(posedge ref_clk_i);
        while (pready !== 1'b1) @(posedge ref_clk_i);
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        trig <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task tk(input int k);
        repeat (k) begin
            tick <= 1'b1;
            @(posedge ref_clk_i);
            tick <= 1'b0;
            @(posedge ref_clk_i);
        end
    endtask
    task ext(input logic [3:0] p, input logic [3:0] h);
        pulses <= p;
        half <= h;
        start <= 1'b1;
        @(posedge ref_clk_i);
        start <= 1'b0;
        @(posedge ref_clk_i);
        repeat (200) if (ext_busy === 1'b1) @(posedge ref_clk_i);
        repeat (4) @(posedge ref_clk_i);
    endtask
    task stop_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(`OFS_CONTROL, 32'h0);
        rd(12'h0fc, 32'h0);
        chk("pslverr", 32'h1, perr);
        wr(`OFS_COUNT_HIGH, 32'hab);
        wr(`OFS_COUNT_LOW, 32'hcd);
        chk("count", 32'habcd, count);
        for (int p = 0; p < 4; p++) begin
            n = {$random(seed)} % 24;
            wr(`OFS_CONTROL, 32'h1 | (p << 4));
            tk(3);
            wr(`OFS_COUNT_LOW, 32'h0);
            wr(`OFS_COUNT_HIGH, 32'h0);
            tk(n);
            chk("count", n >> p, count);
        end
        wr(`OFS_CONTROL, 32'h30);
        tk(4);
        chk("count", n >> 3, count);
        for (int g = 0; g < 4; g++) begin
            gate_pin <= g[0] ^ g[1];
            comp2 <= g[0] ^ !g[1];
            wr(`OFS_COUNT_LOW, 32'h0);
            wr(`OFS_CONTROL, 32'h41 | (g[0] << 7) | (g[1] << 8));
            tk(5);
            gate_pin <= !(g[0] ^ g[1]);
            comp2 <= !(g[0] ^ !g[1]);
            repeat (3) @(posedge ref_clk_i);
            tk(4);
            chk("count", 32'h5, count);
        end
        wr(`OFS_CONTROL, 32'h1);
        wr(`OFS_IRQ_ENABLE, 32'h7);
        wr(`OFS_COUNT_LOW, 32'hff);
        wr(`OFS_COUNT_HIGH, 32'hff);
        tk(1);
        chk("count", 32'h0, count);
        rd(`OFS_STATUS, 32'h1);
        chk("irq", 32'h1, irq);
        wr(`OFS_IRQ_ENABLE, 32'h3);
        chk("irq", 32'h0, irq);
        wr(`OFS_STATUS, 32'h0);
        wr(`OFS_COUNT_HIGH, 32'h12);
        trig <= 1'b1;
        @(posedge ref_clk_i);
        trig <= 1'b0;
        @(posedge ref_clk_i);
        chk("count", 32'h0, count);
        rd(`OFS_STATUS, 32'h0);
        wr(`OFS_COUNT_HIGH, 32'h12);
        trig_acc = 1'b1;
        wr(`OFS_COUNT_LOW, 32'h56);
        trig_acc = 1'b0;
        chk("count", 32'h56, count);
        cap <= 1'b1;
        @(posedge ref_clk_i);
        cap <= 1'b0;
        @(posedge ref_clk_i);
        rd(`OFS_CAPTURE_LOW, 32'h56);
        wr(`OFS_COMPARE_LOW, 32'h56);
        chk("match", 32'h1, match);
        port <= 4'h3;
        mode_ok <= 1'b1;
        wr(`OFS_CONTROL, 32'h8);
        chk("osc_run", 32'h1, osc_run);
        rd(`OFS_OSC_PORT, 32'hc);
        mode_ok <= 1'b0;
        @(posedge ref_clk_i);
        chk("osc_run", 32'h0, osc_run);
        wr(`OFS_CONTROL, 32'h0);
        rd(`OFS_OSC_PORT, 32'h3);
        for (int s = 0; s < 2; s++) begin
            sleep <= s[0];
            wr(`OFS_CONTROL, 32'h2 | (s << 2));
            wr(`OFS_COUNT_LOW, 32'h0);
            wr(`OFS_COUNT_HIGH, 32'h0);
            wr(`OFS_CONTROL, 32'h3 | (s << 2));
            ext(4'h3, 4'h2 + 4'h3 * s[3:0]);
            chk("count", 32'h2, count);
        end
        wr(`OFS_CONTROL, 32'h6);
        wr(`OFS_IRQ_ENABLE, 32'h7);
        wr(`OFS_COUNT_LOW, 32'hff);
        wr(`OFS_COUNT_HIGH, 32'hff);
        wr(`OFS_CONTROL, 32'h7);
        ext(4'h2, 4'h3);
        chk("count", 32'h0, count);
        chk("wake", 32'h1, wake_n);
        chk("vector", 32'h1, vec_n);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        stop_test();
    end
endmodule
